/* core/port_d_alt_function_override.v */
// Port D alternate function override logic with plain port registers and MCU control
`include "port_d_alt_regs.vh"

module port_d_alt_function_override #(
   parameter WIDTH = 8
) (
   input wire mclk,
   input wire reset,
   // Register port
   input wire [5:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   // Pads
   input wire [WIDTH-1:0] pad_in,
   output wire [WIDTH-1:0] pad_oe,
   output wire [WIDTH-1:0] pad_out,
   output wire [WIDTH-1:0] pad_pullup,
   output wire [WIDTH-1:0] pad_input_enable,
   // Serial port
   input wire transmitter_enable,
   input wire transmit_data,
   input wire receiver_enable,
   output wire receive_data,
   input wire serial_mode_select,
   input wire serial_clock_out,
   output wire serial_clock_in,
   // Timers
   input wire timer0_compare_a_enable,
   input wire timer0_compare_a_out,
   input wire timer0_compare_b_enable,
   input wire timer0_compare_b_out,
   input wire timer2_compare_b_enable,
   input wire timer2_compare_b_out,
   output wire timer0_count_input,
   output wire timer1_count_input,
   // External interrupts and pin change
   input wire ext_irq_0_enable,
   input wire ext_irq_1_enable,
   output wire ext_irq_0,
   output wire ext_irq_1,
   input wire [WIDTH-1:0] pin_change_mask,
   input wire pin_change_group2_enable,
   output wire [WIDTH-1:0] pin_change_src,
   // Control bits held for other blocks, and brown-out bits read in from outside
   output wire global_pullup_disable,
   output wire vector_table_select,
   output wire vector_change_unlock,
   input wire brownout_sleep,
   input wire brownout_sleep_unlock
);

   // Plain port registers
   reg [WIDTH-1:0] dir_reg; // Direction, 1 = output
   reg [WIDTH-1:0] out_reg; // Output value / pull-up request
   reg [7:0] mcu_control; // Writable bits only
   reg [WIDTH-1:0] pin_sync; // Registered pin image for reads

   // Per-pin override vectors
   reg [WIDTH-1:0] pullup_override_enable;
   reg [WIDTH-1:0] pullup_override_value;
   reg [WIDTH-1:0] dir_override_enable;
   reg [WIDTH-1:0] dir_override_value;
   reg [WIDTH-1:0] value_override_enable;
   reg [WIDTH-1:0] value_override_value;
   reg [WIDTH-1:0] input_enable_override_enable;

   // Decode shared by read and write paths
   function is_addr;
      input [5:0] a;
      input [5:0] ofs;
      begin
         is_addr = (a == ofs);
      end
   endfunction

   assign global_pullup_disable = mcu_control[`GLOBAL_PULLUP_DISABLE_BIT];
   assign vector_table_select = mcu_control[`VECTOR_TABLE_SELECT_BIT];
   assign vector_change_unlock = mcu_control[`VECTOR_CHANGE_UNLOCK_BIT];

   // Register writes
   always @(posedge mclk) begin
      if (reset) begin
         dir_reg <= {WIDTH{1'b0}};
         out_reg <= {WIDTH{1'b0}};
         mcu_control <= `MCU_CONTROL_RESET;
      end else if (wr) begin
         if (is_addr(addr, `DIR_REG_OFS)) begin
            dir_reg <= wdata[WIDTH-1:0];
         end
         if (is_addr(addr, `OUT_REG_OFS)) begin
            out_reg <= wdata[WIDTH-1:0];
         end
         if (is_addr(addr, `MCU_CONTROL_OFS)) begin
            // Only pull-up disable and vector bits are writable
            mcu_control <= wdata & `MCU_CONTROL_WRITE_MASK;
         end
      end
   end

   // Pin image sampled each clock; inputs are already synchronous
   always @(posedge mclk) begin
      if (reset) begin
         pin_sync <= {WIDTH{1'b0}};
      end else begin
         pin_sync <= pad_in & pad_input_enable;
      end
   end

   // Register reads: data stand the cycle after the strobe
   always @(posedge mclk) begin
      if (reset) begin
         rdata <= 8'h00;
      end else if (rd) begin
         if (is_addr(addr, `DIR_REG_OFS)) begin
            rdata <= dir_reg;
         end else if (is_addr(addr, `OUT_REG_OFS)) begin
            rdata <= out_reg;
         end else if (is_addr(addr, `PIN_REG_OFS)) begin
            rdata <= pin_sync;
         end else if (is_addr(addr, `MCU_CONTROL_OFS)) begin
            // Brown-out bits are read-only views; unused bits zero
            rdata <= {1'b0, brownout_sleep, brownout_sleep_unlock, mcu_control[4], 2'b00,
                      mcu_control[1:0]};
         end else begin
            // Unmapped offsets read zero
            rdata <= 8'h00;
         end
      end else begin
         rdata <= 8'h00;
      end
   end

   // Override table: defaults are "no override", pins follow plain registers
   always @* begin
      pullup_override_enable = {WIDTH{1'b0}};
      pullup_override_value = {WIDTH{1'b0}};
      dir_override_enable = {WIDTH{1'b0}};
      dir_override_value = {WIDTH{1'b0}};
      value_override_enable = {WIDTH{1'b0}};
      value_override_value = {WIDTH{1'b0}};
      // Any masked pin in an enabled group keeps its input alive
      input_enable_override_enable = pin_change_mask & {WIDTH{pin_change_group2_enable}};

      // Receive pin: forced input, pull-up still follows out bit
      pullup_override_enable[`PIN_RX] = receiver_enable;
      pullup_override_value[`PIN_RX] = out_reg[`PIN_RX] & ~global_pullup_disable;
      dir_override_enable[`PIN_RX] = receiver_enable;
      dir_override_value[`PIN_RX] = 1'b0;

      // Transmit pin: forced output carrying data, no pull-up
      pullup_override_enable[`PIN_TX] = transmitter_enable;
      pullup_override_value[`PIN_TX] = 1'b0;
      dir_override_enable[`PIN_TX] = transmitter_enable;
      dir_override_value[`PIN_TX] = 1'b1;
      value_override_enable[`PIN_TX] = transmitter_enable;
      value_override_value[`PIN_TX] = transmit_data;

      // Interrupt 0 pin; group 2 used here, the printed group 1 looks like a slip
      input_enable_override_enable[`PIN_IRQ0] = ext_irq_0_enable |
         (pin_change_mask[`PIN_IRQ0] & pin_change_group2_enable);

      // Pin 3: interrupt 1 input and timer 2 compare B output
      input_enable_override_enable[`PIN_TIMER2_COMPARE_B_OUT] = ext_irq_1_enable |
         (pin_change_mask[`PIN_TIMER2_COMPARE_B_OUT] & pin_change_group2_enable);
      value_override_enable[`PIN_TIMER2_COMPARE_B_OUT] = timer2_compare_b_enable;
      value_override_value[`PIN_TIMER2_COMPARE_B_OUT] = timer2_compare_b_out;

      // Pin 4: serial clock output only in synchronous mode
      value_override_enable[`PIN_XCK] = serial_mode_select;
      value_override_value[`PIN_XCK] = serial_clock_out;

      // Compare outputs only reach the pin when software sets direction
      value_override_enable[`PIN_TIMER0_COMPARE_B_OUT] = timer0_compare_b_enable;
      value_override_value[`PIN_TIMER0_COMPARE_B_OUT] = timer0_compare_b_out;
      value_override_enable[`PIN_TIMER0_COMPARE_A_OUT] = timer0_compare_a_enable;
      value_override_value[`PIN_TIMER0_COMPARE_A_OUT] = timer0_compare_a_out;
   end

   // One cell per pin
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_pin
         pin_cell u_cell (
            .dir_bit(dir_reg[i]),
            .out_bit(out_reg[i]),
            .pullup_disable(global_pullup_disable),
            .pullup_override_enable(pullup_override_enable[i]),
            .pullup_override_value(pullup_override_value[i]),
            .dir_override_enable(dir_override_enable[i]),
            .dir_override_value(dir_override_value[i]),
            .value_override_enable(value_override_enable[i]),
            .value_override_value(value_override_value[i]),
            .input_enable_override_enable(input_enable_override_enable[i]),
            .input_enable_override_value(1'b1),
            .input_enable_default(1'b1),
            .pad_oe(pad_oe[i]),
            .pad_out(pad_out[i]),
            .pad_pullup(pad_pullup[i]),
            .pad_input_enable(pad_input_enable[i])
         );
      end
   endgenerate

   // Digital inputs handed to peripherals; comparator pin 7 reaches only pin_change_src
   wire [WIDTH-1:0] pin_digital = pad_in & pad_input_enable;
   assign receive_data = pin_digital[`PIN_RX];
   assign ext_irq_0 = pin_digital[`PIN_IRQ0];
   assign ext_irq_1 = pin_digital[`PIN_TIMER2_COMPARE_B_OUT];
   assign serial_clock_in = pin_digital[`PIN_XCK];
   assign timer0_count_input = pin_digital[`PIN_XCK];
   assign timer1_count_input = pin_digital[`PIN_TIMER0_COMPARE_B_OUT];
   assign pin_change_src = pin_digital;

endmodule // port_d_alt_function_override

/* include/port_d_alt_regs.vh */
// Register offsets, field positions, reset values and pin indices for the port D override block
`ifndef PORT_D_ALT_REGS_VH
`define PORT_D_ALT_REGS_VH

// Register offsets (I/O space)
`define MCU_CONTROL_OFS 6'h35
`define DIR_REG_OFS 6'h0A
`define OUT_REG_OFS 6'h0B
`define PIN_REG_OFS 6'h09
`define ALT_CTRL_OFS 6'h30

// Reset values
`define MCU_CONTROL_RESET 8'h00
`define PORT_RESET 8'h00
`define ALT_CTRL_RESET 8'h00

// MCU control fields
`define GLOBAL_PULLUP_DISABLE_BIT 4
`define VECTOR_TABLE_SELECT_BIT 1
`define VECTOR_CHANGE_UNLOCK_BIT 0
`define MCU_CONTROL_WRITE_MASK 8'h13

// Pin indices
`define PIN_RX 0
`define PIN_TX 1
`define PIN_IRQ0 2
`define PIN_TIMER2_COMPARE_B_OUT 3
`define PIN_XCK 4
`define PIN_TIMER0_COMPARE_B_OUT 5
`define PIN_TIMER0_COMPARE_A_OUT 6
`define PIN_COMPARATOR_NEG_IN 7

`endif

/* core/pin_cell.v */
// One port pin: merges plain port controls with override signals into pad controls
module pin_cell (
   input wire dir_bit,
   input wire out_bit,
   input wire pullup_disable,
   input wire pullup_override_enable,
   input wire pullup_override_value,
   input wire dir_override_enable,
   input wire dir_override_value,
   input wire value_override_enable,
   input wire value_override_value,
   input wire input_enable_override_enable,
   input wire input_enable_override_value,
   input wire input_enable_default,
   output wire pad_oe,
   output wire pad_out,
   output wire pad_pullup,
   output wire pad_input_enable
);

   // Effective direction and output level
   wire eff_dir = dir_override_enable ? dir_override_value : dir_bit;
   assign pad_oe = eff_dir;
   assign pad_out = value_override_enable ? value_override_value : out_bit;

   // Pull-up only on an input with output bit set, killed by global disable
   assign pad_pullup = pullup_override_enable ? pullup_override_value
                       : (~eff_dir & out_bit & ~pullup_disable);

   // Input buffer enable
   assign pad_input_enable = input_enable_override_enable ? input_enable_override_value
                             : input_enable_default;

endmodule // pin_cell

/* tb/port_d_checker_assertions.sv */
// Concurrent checks on the port D override block ports
`include "port_d_alt_regs.vh"
module port_d_checker (
   input logic mclk, reset, wr, rd,
   input logic [5:0] addr,
   input logic [7:0] wdata, rdata, pad_in, pad_oe, pad_out, pad_pullup,
   input logic [7:0] pad_input_enable, pin_change_mask, pin_change_src,
   input logic transmitter_enable, transmit_data, receiver_enable, receive_data,
   input logic serial_mode_select, serial_clock_out, timer0_compare_a_enable, timer0_compare_a_out,
   input logic timer0_count_input, timer1_count_input, ext_irq_0_enable, ext_irq_0,
   input logic pin_change_group2_enable, global_pullup_disable, vector_table_select,
   input logic vector_change_unlock, brownout_sleep, brownout_sleep_unlock
);
   timeunit 1ns;
   timeprecision 1ns;
   // Single clock domain, so one default clock and reset
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   tx_drive_a: assert property (transmitter_enable |-> pad_oe[1] && !pad_pullup[1] && pad_out[1] == transmit_data)
      else $error("transmit pin not driven");
   rx_input_a: assert property (receiver_enable |-> !pad_oe[0] && receive_data == pad_in[0])
      else $error("receive pin not an input");
   timer0_compare_a_out_value_a: assert property (timer0_compare_a_enable |-> pad_out[6] == timer0_compare_a_out)
      else $error("compare A value lost");
   xck_value_a: assert property (serial_mode_select |-> pad_out[4] == serial_clock_out)
      else $error("serial clock value lost");
   count_src_a: assert property (timer0_count_input == (pad_in[4] & pad_input_enable[4])
      && timer1_count_input == (pad_in[5] & pad_input_enable[5])) else $error("count source wrong");
   pcint_enable_a: assert property (pin_change_group2_enable |->
      (pad_input_enable & pin_change_mask) == pin_change_mask && pin_change_src == (pad_in & pad_input_enable))
      else $error("pin change input off");
   irq0_enable_a: assert property (ext_irq_0_enable |-> pad_input_enable[2] && ext_irq_0 == pad_in[2])
      else $error("irq 0 input off");
   pud_all_a: assert property (global_pullup_disable |-> pad_pullup == 8'h00)
      else $error("pull-up active while disabled");
   mcu_write_a: assert property (wr && addr == `MCU_CONTROL_OFS |=> global_pullup_disable == $past(wdata[4]))
      else $error("pull-up disable not written");
   mcu_read_a: assert property (rd && addr == `MCU_CONTROL_OFS |=> rdata == {1'b0, $past(brownout_sleep),
      $past(brownout_sleep_unlock), global_pullup_disable, 2'h0, vector_table_select, vector_change_unlock})
      else $error("control read wrong");
endmodule // port_d_checker

bind port_d_alt_function_override port_d_checker chk (.*);

/* tb/pin_world.sv */
// Model of the circuitry outside the port pins
module pin_world (
   input logic mclk,
   input logic [7:0] pad_oe, pad_out, pad_pullup, ext_en, ext_val,
   output logic [7:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] float_pat = 8'h55; // Undriven level, flips so it never looks settled
   // Keep a floating pin changing every cycle
   always @(posedge mclk) begin
      float_pat <= ~float_pat;
   end
   // Pad driver wins, then outside source, then pull-up; bench keeps pin 7 input, no pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : pad_pullup[i] ? 1'b1 : float_pat[i];
      end
   end
endmodule // pin_world

/* tb/tb.sv */
// Self-checking bench for the port D override block
`include "port_d_alt_regs.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0; // Clock, reset, strobes
   logic [5:0] addr = 6'h00;
   logic [7:0] wdata = 8'h00, ext_en = 8'h00, ext_val = 8'h00, pin_change_mask = 8'h00;
   logic [7:0] rdata, pad_in, pad_oe, pad_out, pad_pullup, pad_input_enable, pin_change_src;
   logic transmitter_enable = 1'b0, transmit_data = 1'b0, receiver_enable = 1'b0, serial_mode_select = 1'b0;
   logic serial_clock_out = 1'b0, timer0_compare_a_enable = 1'b0, timer0_compare_a_out = 1'b0;
   logic timer0_compare_b_enable = 1'b0, timer0_compare_b_out = 1'b0, timer2_compare_b_enable = 1'b0;
   logic timer2_compare_b_out = 1'b0, ext_irq_0_enable = 1'b0, ext_irq_1_enable = 1'b0;
   logic pin_change_group2_enable = 1'b0, brownout_sleep = 1'b0, brownout_sleep_unlock = 1'b0;
   logic receive_data, serial_clock_in, timer0_count_input, timer1_count_input, ext_irq_0, ext_irq_1;
   logic global_pullup_disable, vector_table_select, vector_change_unlock;
   int n_mismatch = 0, check_count = 0;
   port_d_alt_function_override dut (.*);
   pin_world world (.*);
   // 20 MHz clock
   initial begin
      forever #25 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One-cycle write strobe
   task automatic wreg(input logic [5:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   // Read strobe, data taken only in the following cycle
   task automatic rchk(input logic [5:0] a, input logic [7:0] exp, input string what);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      chk(what, exp, rdata);
   endtask
   task automatic t_regs;
      rchk(`MCU_CONTROL_OFS, 8'h00, "mcu reset");
      brownout_sleep <= 1'b1;
      wreg(`MCU_CONTROL_OFS, 8'hFF);
      rchk(`MCU_CONTROL_OFS, 8'h53, "mcu masked");
      rchk(6'h3F, 8'h00, "unmapped");
      wreg(`MCU_CONTROL_OFS, 8'h00);
      brownout_sleep <= 1'b0;
      $display("test regs done");
   endtask
   task automatic t_default;
      ext_en <= 8'hC0;
      ext_val <= 8'h80;
      wreg(`DIR_REG_OFS, 8'h0F);
      wreg(`OUT_REG_OFS, 8'h33);
      @(negedge mclk);
      chk("oe", 8'h0F, pad_oe);
      chk("out", 8'h33, pad_out);
      chk("pullup", 8'h30, pad_pullup);
      rchk(`PIN_REG_OFS, 8'hB3, "pins");
      wreg(`MCU_CONTROL_OFS, 8'h10);
      @(negedge mclk);
      chk("pud", 8'h00, pad_pullup);
      wreg(`MCU_CONTROL_OFS, 8'h00);
      $display("test default done");
   endtask
   task automatic t_serial;
      wreg(`DIR_REG_OFS, 8'h01);
      wreg(`OUT_REG_OFS, 8'h03);
      transmitter_enable <= 1'b1;
      receiver_enable <= 1'b1;
      ext_en <= 8'h01;
      ext_val <= 8'h01;
      @(negedge mclk);
      chk("oe", 8'h02, pad_oe);
      chk("tx", 8'h00, {7'h00, pad_out[1]});
      chk("pullup", 8'h01, pad_pullup);
      chk("rx", 8'h01, {7'h00, receive_data});
      transmit_data <= 1'b1;
      ext_val <= 8'h00;
      wreg(`MCU_CONTROL_OFS, 8'h10);
      @(negedge mclk);
      chk("tx", 8'h01, {7'h00, pad_out[1]});
      chk("pullup", 8'h00, pad_pullup);
      chk("rx", 8'h00, {7'h00, receive_data});
      wreg(`MCU_CONTROL_OFS, 8'h00);
      transmitter_enable <= 1'b0;
      receiver_enable <= 1'b0;
      $display("test serial done");
   endtask
   task automatic t_timers;
      wreg(`DIR_REG_OFS, 8'h68);
      wreg(`OUT_REG_OFS, 8'h78);
      {timer0_compare_a_enable, timer0_compare_b_enable, timer2_compare_b_enable, serial_mode_select} <= 4'hF;
      ext_en <= 8'h10;
      ext_val <= 8'h10;
      @(negedge mclk);
      chk("values", 8'h00, pad_out);
      chk("counts", 8'h01, {6'h00, timer1_count_input, timer0_count_input});
      {timer0_compare_a_out, timer0_compare_b_out, timer2_compare_b_out, serial_clock_out} <= 4'hF;
      ext_val <= 8'h00;
      wreg(`OUT_REG_OFS, 8'h00);
      @(negedge mclk);
      chk("values", 8'h78, pad_out);
      chk("counts", 8'h02, {6'h00, timer1_count_input, timer0_count_input});
      serial_mode_select <= 1'b0;
      ext_val <= 8'h10;
      @(negedge mclk);
      chk("clock in", 8'h01, {7'h00, serial_clock_in});
      $display("test timers done");
   endtask
   task automatic t_irq;
      wreg(`DIR_REG_OFS, 8'h00);
      ext_en <= 8'hFF;
      ext_val <= 8'hA5;
      {ext_irq_0_enable, ext_irq_1_enable, pin_change_group2_enable} <= 3'h7;
      pin_change_mask <= 8'hFF;
      @(negedge mclk);
      chk("ie", 8'hFF, pad_input_enable);
      chk("pcint", 8'hA5, pin_change_src);
      chk("irq", 8'h01, {6'h00, ext_irq_1, ext_irq_0});
      $display("test irq done");
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Main sequence after six reset cycles
   initial begin
      repeat (6) @(posedge mclk);
      reset <= 1'b0;
      t_regs();
      t_default();
      t_serial();
      t_timers();
      t_irq();
      final_report();
   end
   // Hang guard, well past the roughly 45 cycles the tests need
   initial begin
      #200000;
      n_mismatch++;
      final_report();
   end
endmodule // tb
